// ### src/rtcci_consts.svh
`ifndef RTCCI_CONSTS_SVH
`define RTCCI_CONSTS_SVH

// Register offsets
`define RTCCI_OFS_CTRL1 4'h0
`define RTCCI_OFS_CTRL2 4'h1
`define RTCCI_OFS_SECS 4'h2

// Field positions, first control register
`define RTCCI_BIT_TEST 7
`define RTCCI_BIT_STOP 5
`define RTCCI_BIT_OVRD 3
// Field positions, second control register
`define RTCCI_BIT_PULSE 4
`define RTCCI_BIT_AF 3
`define RTCCI_BIT_TF 2
`define RTCCI_BIT_AIE 1
`define RTCCI_BIT_TIE 0
// Field positions, seconds register
`define RTCCI_BIT_VL 7

// Reset values
`define RTCCI_RST_TEST 1'b0
`define RTCCI_RST_STOP 1'b0
`define RTCCI_RST_OVRD 1'b1
`define RTCCI_RST_VL 1'b1
`define RTCCI_RST_SECS 7'h00

// Timing: clock rate and divider chain
`define RTCCI_CLK_HZ 20000000
`define RTCCI_SQW_HZ 32768
// Pulse widths, as fractions of a second (denominators)
`define RTCCI_PW_DIV_8192 8192
`define RTCCI_PW_DIV_4096 4096
`define RTCCI_PW_DIV_128 128
`define RTCCI_PW_DIV_64 64
// Timer source selection codes
`define RTCCI_SRC_4096 2'h0
`define RTCCI_SRC_64 2'h1
`define RTCCI_SRC_1 2'h2
`define RTCCI_SRC_MIN 2'h3

`endif

// ### src/rtcci_pkg.sv
package rtcci_pkg;

  // One register access from the serial engine
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } rtcci_reg_req_type;

  // Countdown timer request from the timer register logic
  typedef struct packed {
    logic load;
    logic run;
    logic [1:0] src;
    logic [7:0] count;
  } rtcci_timer_req_type;

  // Pulse generator states
  typedef enum logic [1:0] {
    RTCCI_PS_IDLE = 2'b01,
    RTCCI_PS_HIGH = 2'b10
  } rtcci_pstate_type;

endpackage

// ### src/rtcci_pulse.sv
`timescale 1ns/100ps
`default_nettype none
module rtcci_pulse
  import rtcci_pkg::*;
#(
  parameter int WW = 19
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [WW-1:0] width,
  output logic active
);

  rtcci_pstate_type state_q, state_d;
  logic [WW-1:0] cnt_q, cnt_d;

  //////////////////////////////////////////////////////////////////
  // Next state: start while high reloads the count, so a late event of equal width never shortens; from idle it starts only if width exceeds one
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      RTCCI_PS_IDLE: begin
        if (start && (width > WW'(1))) begin
          state_d = RTCCI_PS_HIGH;
          cnt_d = width - WW'(2);
        end
      end
      RTCCI_PS_HIGH: begin
        if (start) begin
          cnt_d = width - WW'(2);
        end else if (cnt_q == '0) begin
          state_d = RTCCI_PS_IDLE;
        end else begin
          cnt_d = cnt_q - WW'(1);
        end
      end
      default: begin
        state_d = RTCCI_PS_IDLE;
        cnt_d = '0;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= RTCCI_PS_IDLE;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  assign active = (state_q == RTCCI_PS_HIGH);

endmodule
`default_nettype wire

// ### src/rtcci_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "rtcci_consts.svh"
module rtcci_top
  import rtcci_pkg::*;
#(
  parameter int CLK_HZ = `RTCCI_CLK_HZ,
  parameter int PW8192_CYC = `RTCCI_CLK_HZ / `RTCCI_PW_DIV_8192,
  parameter int PW4096_CYC = `RTCCI_CLK_HZ / `RTCCI_PW_DIV_4096,
  parameter int PW128_CYC = `RTCCI_CLK_HZ / `RTCCI_PW_DIV_128,
  parameter int PW64_CYC = `RTCCI_CLK_HZ / `RTCCI_PW_DIV_64
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire rtcci_reg_req_type REG_REQ,
  output logic [7:0] REG_RDATA,
  input wire logic ALARM_EVENT,
  input wire logic LOW_VOLTAGE,
  input wire logic OSC_STOPPED,
  input wire logic EXTERNAL_CLOCK_TEST,
  input wire rtcci_timer_req_type TIMER_REQ,
  output logic [7:0] TIMER_VALUE,
  output logic [6:0] SECONDS_BCD,
  output logic INT_O,
  output logic INT_OE,
  output logic SQUARE_WAVE_OUT,
  output logic RESET_OVERRIDE_ENABLE
);

  localparam int PWW = 19;
  // Phase step for a 65.536 kHz carry out of a 24-bit accumulator
  localparam logic [23:0] SQW_STEP =
    24'((64'(2 * `RTCCI_SQW_HZ) << 24) / 64'(CLK_HZ));

  logic test_mode_sel_q, test_mode_sel_d;
  logic stop_q, stop_d;
  logic ovrd_q, ovrd_d;
  logic pulse_mode_q, pulse_mode_d;
  logic alarm_flag_q, alarm_flag_d;
  logic timer_flag_q, timer_flag_d;
  logic aie_q, aie_d;
  logic tie_q, tie_d;
  logic vl_q, vl_d;
  logic [3:0] sec_units_q, sec_units_d;
  logic [2:0] sec_tens_q, sec_tens_d;
  logic [23:0] acc_q, acc_d;
  logic sqw_q, sqw_d;
  logic [14:0] chain_q, chain_d;
  logic [5:0] minute_q, minute_d;
  logic [7:0] timer_q, timer_d;
  logic [7:0] load_n_q, load_n_d;
  logic [1:0] src_q, src_d;
  logic run_q, run_d;
  logic int_oe_q, int_oe_d;
  logic [7:0] rdata_q, rdata_d;
  logic wr0, wr1, wr2;
  logic carry;
  logic src_tick, tick4096, tick64, tick1, tick_min, timer_tick;
  logic timer_end;
  logic pulse_active;
  logic [PWW-1:0] pulse_width;

  //////////////////////////////////////////////////////////////////
  // Register write decode
  assign wr0 = REG_REQ.wr && (REG_REQ.addr == `RTCCI_OFS_CTRL1);
  assign wr1 = REG_REQ.wr && (REG_REQ.addr == `RTCCI_OFS_CTRL2);
  assign wr2 = REG_REQ.wr && (REG_REQ.addr == `RTCCI_OFS_SECS);

  //////////////////////////////////////////////////////////////////
  // Oscillator model: square wave keeps running whatever the stop bit
  always_comb begin
    {carry, acc_d} = {1'b0, acc_q} + {1'b0, SQW_STEP};
    sqw_d = carry ? ~sqw_q : sqw_q;
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      acc_q <= '0;
      sqw_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      sqw_q <= sqw_d;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Divider chain taps; in test mode the chain steps on the test input
  // test clock select
  assign src_tick = test_mode_sel_q ? EXTERNAL_CLOCK_TEST : (carry && sqw_q);
  assign tick4096 = src_tick && (chain_q[2:0] == 3'h7);
  assign tick64 = src_tick && (chain_q[8:0] == 9'h1ff);
  assign tick1 = src_tick && (chain_q == 15'h7fff);
  assign tick_min = tick1 && (minute_q == 6'd59);

  // Chain next value
  always_comb begin
    chain_d = chain_q;
    minute_d = minute_q;
    if (stop_q) begin
      chain_d = '0;
      minute_d = '0;
    end else if (src_tick) begin
      chain_d = chain_q + 15'h0001;
      if (tick1) begin
        minute_d = tick_min ? 6'd0 : minute_q + 6'd1;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      chain_q <= '0;
      minute_q <= '0;
    end else begin
      chain_q <= chain_d;
      minute_q <= minute_d;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Countdown timer
  always_comb begin
    case (src_q)
      `RTCCI_SRC_4096: timer_tick = tick4096;
      `RTCCI_SRC_64: timer_tick = tick64;
      `RTCCI_SRC_1: timer_tick = tick1;
      default: timer_tick = tick_min;
    endcase
  end

  // End of countdown is the step from one to zero
  assign timer_end = run_q && timer_tick && !stop_q && (timer_q == 8'h01);

  always_comb begin
    timer_d = timer_q;
    load_n_d = load_n_q;
    src_d = src_q;
    run_d = TIMER_REQ.run;
    if (TIMER_REQ.load) begin
      timer_d = TIMER_REQ.count;
      load_n_d = TIMER_REQ.count;
      src_d = TIMER_REQ.src;
    end else if (run_q && timer_tick && !stop_q && (timer_q != 8'h00)) begin
      timer_d = timer_q - 8'h01;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      timer_q <= '0;
      load_n_q <= '0;
      src_q <= `RTCCI_SRC_4096;
      run_q <= 1'b0;
    end else begin
      timer_q <= timer_d;
      load_n_q <= load_n_d;
      src_q <= src_d;
      run_q <= run_d;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Control registers and flags
  always_comb begin
    test_mode_sel_d = test_mode_sel_q;
    stop_d = stop_q;
    ovrd_d = ovrd_q;
    pulse_mode_d = pulse_mode_q;
    aie_d = aie_q;
    tie_d = tie_q;
    // Unused bits are not stored, so stray ones read back as zero
    if (wr0) begin
      test_mode_sel_d = REG_REQ.wdata[`RTCCI_BIT_TEST];
      stop_d = REG_REQ.wdata[`RTCCI_BIT_STOP];
      ovrd_d = REG_REQ.wdata[`RTCCI_BIT_OVRD];
    end
    if (wr1) begin
      pulse_mode_d = REG_REQ.wdata[`RTCCI_BIT_PULSE];
      aie_d = REG_REQ.wdata[`RTCCI_BIT_AIE];
      tie_d = REG_REQ.wdata[`RTCCI_BIT_TIE];
    end
    alarm_flag_d = alarm_flag_q & ~(wr1 & ~REG_REQ.wdata[`RTCCI_BIT_AF]);
    timer_flag_d = timer_flag_q & ~(wr1 & ~REG_REQ.wdata[`RTCCI_BIT_TF]);
    // event sets flag; set wins over a clear in the same cycle
    if (ALARM_EVENT) begin
      alarm_flag_d = 1'b1;
    end
    if (timer_end) begin
      timer_flag_d = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      test_mode_sel_q <= `RTCCI_RST_TEST;
      stop_q <= `RTCCI_RST_STOP;
      ovrd_q <= `RTCCI_RST_OVRD;
      pulse_mode_q <= 1'b0;
      alarm_flag_q <= 1'b0;
      timer_flag_q <= 1'b0;
      aie_q <= 1'b0;
      tie_q <= 1'b0;
    end else begin
      test_mode_sel_q <= test_mode_sel_d;
      stop_q <= stop_d;
      ovrd_q <= ovrd_d;
      pulse_mode_q <= pulse_mode_d;
      alarm_flag_q <= alarm_flag_d;
      timer_flag_q <= timer_flag_d;
      aie_q <= aie_d;
      tie_q <= tie_d;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Seconds and integrity flag; a write in the tick cycle wins
  always_comb begin
    sec_units_d = sec_units_q;
    sec_tens_d = sec_tens_q;
    vl_d = vl_q || LOW_VOLTAGE || OSC_STOPPED;
    if (wr2) begin
      vl_d = REG_REQ.wdata[`RTCCI_BIT_VL] || LOW_VOLTAGE || OSC_STOPPED;
      sec_units_d = REG_REQ.wdata[3:0];
      sec_tens_d = REG_REQ.wdata[6:4];
    end else if (tick1 && !stop_q) begin
      if (sec_units_q >= 4'd9) begin
        sec_units_d = 4'd0;
        sec_tens_d = (sec_tens_q >= 3'd5) ? 3'd0 : sec_tens_q + 3'd1;
      end else begin
        sec_units_d = sec_units_q + 4'd1;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      vl_q <= `RTCCI_RST_VL;
      {sec_tens_q, sec_units_q} <= `RTCCI_RST_SECS;
    end else begin
      vl_q <= vl_d;
      sec_units_q <= sec_units_d;
      sec_tens_q <= sec_tens_d;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Pulse width: the generator's internal clock ties width to source and count
  always_comb begin
    case (src_q)
      `RTCCI_SRC_4096: begin
        pulse_width = (load_n_q == 8'h01) ? PWW'(PW8192_CYC) : PWW'(PW4096_CYC);
      end
      `RTCCI_SRC_64: begin
        pulse_width = (load_n_q == 8'h01) ? PWW'(PW128_CYC) : PWW'(PW64_CYC);
      end
      default: pulse_width = PWW'(PW64_CYC);
    endcase
  end

  rtcci_pulse #(
    .WW(PWW)
  ) u_pulse (
    .clk(REF_CLK),
    .rst(RST),
    .start(timer_end),
    .width(pulse_width),
    .active(pulse_active)
  );

  //////////////////////////////////////////////////////////////////
  // Interrupt request, built from next values: the pin moves with the alarm flag, and with the timer flag only in level mode
  always_comb begin
    if (!pulse_mode_d) begin
      int_oe_d = timer_flag_d && tie_d;
    end else begin
      int_oe_d = (timer_end || pulse_active) && tie_d;
    end
    int_oe_d = int_oe_d || (alarm_flag_d && aie_d);
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      int_oe_q <= 1'b0;
    end else begin
      int_oe_q <= int_oe_d;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Read data register; addresses outside this block read zero
  always_comb begin
    rdata_d = rdata_q;
    if (REG_REQ.rd) begin
      case (REG_REQ.addr)
        `RTCCI_OFS_CTRL1: begin
          rdata_d = 8'h00;
          rdata_d[`RTCCI_BIT_TEST] = test_mode_sel_q;
          rdata_d[`RTCCI_BIT_STOP] = stop_q;
          rdata_d[`RTCCI_BIT_OVRD] = ovrd_q;
        end
        `RTCCI_OFS_CTRL2: begin
          rdata_d = 8'h00;
          rdata_d[`RTCCI_BIT_PULSE] = pulse_mode_q;
          rdata_d[`RTCCI_BIT_AF] = alarm_flag_q;
          rdata_d[`RTCCI_BIT_TF] = timer_flag_q;
          rdata_d[`RTCCI_BIT_AIE] = aie_q;
          rdata_d[`RTCCI_BIT_TIE] = tie_q;
        end
        `RTCCI_OFS_SECS: rdata_d = {vl_q, sec_tens_q, sec_units_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops except INT_O, which is a constant zero
  assign REG_RDATA = rdata_q;
  assign TIMER_VALUE = timer_q;
  assign SECONDS_BCD = {sec_tens_q, sec_units_q};
  assign INT_O = 1'b0; // Pin only ever pulls low
  assign INT_OE = int_oe_q;
  assign SQUARE_WAVE_OUT = sqw_q;
  assign RESET_OVERRIDE_ENABLE = ovrd_q;

endmodule
`default_nettype wire

// ### bench/rtcci_checker_props.sv
`timescale 1ns/100ps
`default_nettype none
module rtcci_checker
  import rtcci_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire rtcci_reg_req_type REG_REQ,
  input wire logic [7:0] REG_RDATA,
  input wire logic ALARM_EVENT,
  input wire logic LOW_VOLTAGE,
  input wire logic [6:0] SECONDS_BCD,
  input wire logic INT_O,
  input wire logic INT_OE,
  input wire logic RESET_OVERRIDE_ENABLE
);
  // One domain; reset masks every check
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////
  // pin only sinks
  property p_pin_low;
    INT_O == 1'b0;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin driven high");
  property p_reset_vals;
    $fell(RST) |-> REG_RDATA == 8'h00 && !INT_OE && SECONDS_BCD == 7'h00 && RESET_OVERRIDE_ENABLE;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset state");
  // copy checked two edges after the write, once a write-free cycle follows
  property p_ovrd;
    (REG_REQ.wr && REG_REQ.addr == 4'h0) ##1 !REG_REQ.wr
      |=> RESET_OVERRIDE_ENABLE == $past(REG_REQ.wdata[3], 2);
  endproperty
  a_ovrd: assert property (p_ovrd) else $error("override copy wrong");
  property p_bcd;
    SECONDS_BCD[6:4] <= 3'h5 && SECONDS_BCD[3:0] <= 4'h9;
  endproperty
  a_bcd: assert property (p_bcd) else $error("seconds not BCD");
  property p_mask_all;
    REG_REQ.wr && REG_REQ.addr == 4'h1 && REG_REQ.wdata[1:0] == 2'b00 |=> !INT_OE;
  endproperty
  a_mask_all: assert property (p_mask_all) else $error("masked pin active");
  property p_alarm_set;
    (ALARM_EVENT && !REG_REQ.wr) ##1 !REG_REQ.wr ##1
      (REG_REQ.rd && REG_REQ.addr == 4'h1 && !REG_REQ.wr) |=> REG_RDATA[3];
  endproperty
  a_alarm_set: assert property (p_alarm_set) else $error("alarm flag not set");
  property p_alarm_int;
    (REG_REQ.rd && REG_REQ.addr == 4'h1 && !REG_REQ.wr) ##1 (REG_RDATA[3] && REG_RDATA[1])
      |-> INT_OE;
  endproperty
  a_alarm_int: assert property (p_alarm_int) else $error("alarm pin idle");
  property p_timer_level;
    (REG_REQ.rd && REG_REQ.addr == 4'h1 && !REG_REQ.wr) ##1
      (!REG_RDATA[4] && REG_RDATA[2] && REG_RDATA[0]) |-> INT_OE;
  endproperty
  a_timer_level: assert property (p_timer_level) else $error("level pin idle");
  property p_vl_set;
    LOW_VOLTAGE ##1 (REG_REQ.rd && REG_REQ.addr == 4'h2 && !REG_REQ.wr) |=> REG_RDATA[7];
  endproperty
  a_vl_set: assert property (p_vl_set) else $error("integrity flag clear");
endmodule
bind rtcci_top rtcci_checker u_rtcci_checker (.REF_CLK, .RST, .REG_REQ, .REG_RDATA,
  .ALARM_EVENT, .LOW_VOLTAGE, .SECONDS_BCD, .INT_O, .INT_OE, .RESET_OVERRIDE_ENABLE);
`default_nettype wire

// ### bench/rtcci_host.sv
`timescale 1ns/100ps
`default_nettype none
module rtcci_host
  import rtcci_pkg::*;
(
  input wire logic clk,
  output var rtcci_reg_req_type req,
  input wire logic [7:0] rdata
);
  // Strobes idle low so nothing is taken by accident
  initial req = '0;
  // One byte per access; strobe spans exactly one rising edge
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    logic [7:0] m;
    m = (a == 4'h0) ? 8'ha8 : ((a == 4'h1) ? 8'h1f : 8'hff);
    @(negedge clk);
    req = '{rd: !w, wr: w, addr: a, wdata: d & m};
    @(negedge clk);
    // Released lines show inverted junk, never the last value
    req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    q = rdata;
  endtask
endmodule
`default_nettype wire

// ### bench/rtc_control_interrupt_seconds_test.sv
`timescale 1ns/100ps
`default_nettype none
module rtc_control_interrupt_seconds_test
  import rtcci_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic alarm_ev = 1'b0;
  logic low_v = 1'b0;
  logic osc_st = 1'b0;
  logic ext_ck = 1'b0;
  rtcci_timer_req_type treq = '0;
  rtcci_reg_req_type reg_req;
  logic [7:0] rdata, tval, q;
  logic [6:0] secs;
  logic int_o, int_oe, sqw, ovrd, last;
  int fail_count = 0;
  int n_tests = 0;
  int k, n;
  // Reset reads: address then expected byte; 5 is unmapped
  logic [11:0] rst_rows [4] = '{12'h008, 12'h100, 12'h280, 12'h500};
  // Pulse rows: source, count, width in cycles
  int pw_rows [4][3] = '{'{0, 1, 3}, '{0, 2, 5}, '{1, 1, 9}, '{1, 2, 17}};
  ////////////////////////////////////////////////////////////////
  // Free-running clock, 50 ns period
  initial forever #25 ref_clk = ~ref_clk;
  // Short widths and slow core clock keep the run brief
  rtcci_top #(.CLK_HZ(40000), .PW8192_CYC(3), .PW4096_CYC(5), .PW128_CYC(9), .PW64_CYC(17))
  u_rtcci_top (.REF_CLK(ref_clk), .RST(rst), .REG_REQ(reg_req), .REG_RDATA(rdata),
    .ALARM_EVENT(alarm_ev), .LOW_VOLTAGE(low_v), .OSC_STOPPED(osc_st),
    .EXTERNAL_CLOCK_TEST(ext_ck), .TIMER_REQ(treq), .TIMER_VALUE(tval),
    .SECONDS_BCD(secs), .INT_O(int_o), .INT_OE(int_oe), .SQUARE_WAVE_OUT(sqw),
    .RESET_OVERRIDE_ENABLE(ovrd));
  rtcci_host u_rtcci_host (.clk(ref_clk), .req(reg_req), .rdata(rdata));
  ////////////////////////////////////////////////////////////////
  // Byte compare, counted
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask
  // Single exit point
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Register access through the host model
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    u_rtcci_host.acc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string what);
    u_rtcci_host.acc(1'b0, a, 8'h00, q);
    cmp(what, e, q);
  endtask
  // Timer load pulse, run left high
  task automatic load(input logic [1:0] s, input logic [7:0] c);
    @(negedge ref_clk);
    treq = '{load: 1'b1, run: 1'b1, src: s, count: c};
    @(negedge ref_clk);
    treq.load = 1'b0;
  endtask
  // Bounded wait on the pin; a hang ends the run
  task automatic wait_oe(input logic v);
    int i;
    // Two slow ticks from an arbitrary chain phase can take over 3000 cycles
    for (i = 0; i < 4000 && int_oe !== v; i++) @(negedge ref_clk);
    if (int_oe !== v) begin
      fail_count++;
      finish_test();
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence, inputs move on falling edges
  initial begin
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    for (k = 0; k < 4; k++) rd(rst_rows[k][11:8], rst_rows[k][7:0], "reset byte");
    cmp("pin idle", 8'h00, {7'h00, int_oe});
    $display("reset values done");
    wr(4'h0, 8'h00);
    @(negedge ref_clk);
    cmp("override", 8'h00, {7'h00, ovrd});
    wr(4'h1, 8'h11);
    for (k = 0; k < 4; k++) begin
      load(2'(pw_rows[k][0]), 8'(pw_rows[k][1]));
      wait_oe(1'b1);
      n = 0;
      while (int_oe === 1'b1 && n < 100) begin
        n++;
        @(negedge ref_clk);
      end
      cmp("pulse width", 8'(pw_rows[k][2]), 8'(n));
      rd(4'h1, 8'h15, "flags after pulse");
      wr(4'h1, 8'h11);
    end
    $display("pulse rows done");
    wr(4'h1, 8'h01);
    load(2'h0, 8'h01);
    wait_oe(1'b1);
    repeat (30) @(negedge ref_clk);
    cmp("level pin", 8'h01, {7'h00, int_oe});
    cmp("timer held", 8'h00, tval);
    wr(4'h1, 8'h05);
    rd(4'h1, 8'h05, "flag kept");
    wr(4'h1, 8'h01);
    cmp("level pin cleared", 8'h00, {7'h00, int_oe});
    $display("level mode done");
    wr(4'h1, 8'h1e);
    load(2'h0, 8'h01);
    repeat (40) @(negedge ref_clk);
    alarm_ev = 1'b1;
    @(negedge ref_clk);
    alarm_ev = 1'b0;
    rd(4'h1, 8'h1e, "both flags");
    repeat (40) @(negedge ref_clk);
    cmp("alarm holds pin", 8'h01, {7'h00, int_oe});
    wr(4'h1, 8'h16);
    rd(4'h1, 8'h16, "alarm cleared only");
    cmp("pin released", 8'h00, {7'h00, int_oe});
    wr(4'h1, 8'h1a);
    rd(4'h1, 8'h12, "timer cleared only");
    wr(4'h1, 8'h00);
    $display("flags done");
    wr(4'h0, 8'h80);
    load(2'h0, 8'h02);
    repeat (100) @(negedge ref_clk);
    cmp("test mode holds", 8'h02, tval);
    repeat (8) begin
      ext_ck = 1'b1;
      @(negedge ref_clk);
      ext_ck = 1'b0;
      @(negedge ref_clk);
    end
    cmp("test mode step", 8'h01, tval);
    $display("test mode done");
    wr(4'h0, 8'h20);
    load(2'h0, 8'h05);
    n = 0;
    last = sqw;
    for (k = 0; k < 200; k++) begin
      @(negedge ref_clk);
      n = n + ((sqw !== last) ? 1 : 0);
      last = sqw;
    end
    cmp("clock out runs", 8'h01, {7'h00, n > 0});
    cmp("stopped timer", 8'h05, tval);
    wr(4'h0, 8'h00);
    repeat (200) @(negedge ref_clk);
    cmp("timer resumes", 8'h00, tval);
    $display("stop done");
    for (k = 0; k < 2; k++) begin
      wr(4'h2, 8'h10);
      rd(4'h2, 8'h10, "integrity cleared");
      {osc_st, low_v} = 2'(k + 1);
      rd(4'h2, 8'h90, "integrity set");
      {osc_st, low_v} = 2'b00;
    end
    $display("integrity done");
    // The internal tick is far too slow for a full chain turn; step it every cycle
    wr(4'h0, 8'h80);
    ext_ck = 1'b1;
    wr(4'h1, 8'h11);
    load(2'h2, 8'h01);
    wr(4'h2, 8'h59);
    for (k = 0; k < 41000 && secs !== 7'h00; k++) @(negedge ref_clk);
    cmp("seconds wrap", 8'h00, {1'b0, secs});
    n = 0;
    while (int_oe === 1'b1 && n < 100) begin
      n++;
      @(negedge ref_clk);
    end
    cmp("one hertz pulse width", 8'h11, 8'(n));
    ext_ck = 1'b0;
    rd(4'h2, 8'h00, "wrapped byte");
    rd(4'h1, 8'h15, "timer flag at wrap");
    $display("seconds done");
    rst = 1'b1;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    rd(4'h0, 8'h08, "override after reset");
    rd(4'h2, 8'h80, "integrity after reset");
    $display("second reset done");
    finish_test();
  end
endmodule
`default_nettype wire
